// ### shared/bps_consts.svh
// Constants for the buck channel sequencing and fault logic
// Operation
// [RULE1] PWM pin has three states: high, low, released with both switches off.
// [RULE2] Entering released state, hold pin at mid level about 20 ns, then float; the code holds mid level for one 100 ns clock.
// [RULE3] Channel started/stopped by operation command, control pin or input voltage.
// [RULE4] Programmable turn-on delay before start, turn-off delay before stop.
// [RULE5] Host must not request turn-on while turn-off delay still runs.
// [RULE6] Stacked controllers get identical turn-on and turn-off delays.
// [RULE7] Pre-bias: no high side until ramp reaches feedback, then duty ramps up.
// [RULE8] Power-good held low for the whole soft-start.
// [RULE9] After soft-start, power-good rises after 2 ms qualification inside window.
// [RULE10] A configuration bit can disable the 2 ms qualification delay.
// [RULE11] Power-good drops at once when output leaves the window.
// [RULE12] Window limits come from the programmable percentage limit command.
// [RULE13] Peak current above limit ends the current switching pulse.
// [RULE14] Fault threshold and warning threshold come from their own commands.
// [RULE15] Seven successive overcurrent events: both switches off, fault, hiccup by default.
// [RULE16] During soft-start only cycle limiting, no counting toward fault.
// [RULE17] Response setting: latch off until pin toggle, or restart after seven rises.
// [RULE18] Slave channel ignores its response writes and uses channel one's setting.
// [RULE19] Sense resistance setting accepted only from 0.244 to 7.747 milliohm.
// [RULE20] Host programs 0.5 milliohm sense setting in smart stage mode.
// [RULE21] Overcurrent count cleared when disabled or when soft-start begins.
`ifndef BPS_CONSTS_SVH
`define BPS_CONSTS_SVH

`define BPS_CLK_PERIOD_NS   100
`define BPS_PWM_MID_NS      20
// Longest time rounds down, but never below one cycle
`define BPS_PWM_MID_CYC     (((`BPS_PWM_MID_NS / `BPS_CLK_PERIOD_NS) > 0) ? \
                             (`BPS_PWM_MID_NS / `BPS_CLK_PERIOD_NS) : 1)
`define BPS_PG_DELAY_US     2000
`define BPS_PG_DELAY_CYC    ((`BPS_PG_DELAY_US * 1000) / `BPS_CLK_PERIOD_NS)
`define BPS_OC_FAULT_COUNT  7
`define BPS_HICCUP_RISES    7
`define BPS_CAL_MIN_UOHM    16'h00f4
`define BPS_CAL_MAX_UOHM    16'h1e43
`define BPS_CAL_RESET_UOHM  16'h01f4
`define BPS_RESP_RESET      1'b0

`endif

// ### shared/bps_pkg.sv
// Types for the buck channel sequencing and fault logic
package bps_pkg;
  // Gray codes along off, on delay, soft-start, run, off delay, hiccup
  typedef enum logic [2:0] {
    BPS_OFF     = 3'h0,
    BPS_ON_DLY  = 3'h1,
    BPS_SOFT    = 3'h3,
    BPS_RUN     = 3'h2,
    BPS_OFF_DLY = 3'h6,
    BPS_HICCUP  = 3'h7,
    BPS_LATCHED = 3'h5
  } bps_state_t;

  typedef enum logic [1:0] {
    BPS_PWM_REL  = 2'h0,
    BPS_PWM_LOW  = 2'h1,
    BPS_PWM_HIGH = 2'h3
  } bps_pwm_t;
endpackage

// ### src/bps_channel.sv
// One buck channel: start/stop sequencing, PWM pin control, power-good and overcurrent
`timescale 1ns/100ps
`default_nettype none
`include "bps_consts.svh"

module bps_channel #(
  parameter int unsigned CODE_W       = 10,
  parameter int unsigned DLY_W        = 16,
  parameter int unsigned DUTY_W       = 8,
  parameter int unsigned PG_DELAY_CYC = `BPS_PG_DELAY_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              op_on_cmd,
  input  wire logic              use_op_cmd,
  input  wire logic              use_control_pin,
  input  wire logic              channel_control_pin,
  input  wire logic              vin_ok,
  input  wire logic [DLY_W-1:0]  turn_on_delay_cyc,
  input  wire logic [DLY_W-1:0]  turn_off_delay_cyc,
  input  wire logic [DLY_W-1:0]  soft_start_step_cyc,
  input  wire logic [CODE_W-1:0] target_code,
  input  wire logic [CODE_W-1:0] feedback_sense,
  input  wire logic [DUTY_W-1:0] duty_ramp_max,
  input  wire logic              sw_cycle_start,
  input  wire logic              pwm_demand,
  input  wire logic [CODE_W-1:0] peak_current,
  input  wire logic [CODE_W-1:0] oc_fault_limit,
  input  wire logic [CODE_W-1:0] oc_warn_limit,
  input  wire logic [CODE_W-1:0] good_window_lower_limit,
  input  wire logic [CODE_W-1:0] good_window_upper_limit,
  input  wire logic              pg_delay_disable,
  input  wire logic              is_slave,
  input  wire logic              master_oc_latch,
  input  wire logic              oc_resp_wr,
  input  wire logic              oc_resp_latch_data,
  input  wire logic              cal_gain_wr,
  input  wire logic [15:0]       cal_gain_data,
  output logic                   pwm_drive_hi,
  output logic                   pwm_oe,
  output logic                   pwm_mid_en,
  output logic                   power_good_out,
  output logic                   oc_fault,
  output logic                   oc_warn,
  output logic                   oc_resp_latch,
  output logic [15:0]            cal_gain,
  output logic                   cal_gain_reject,
  output logic                   soft_start_active,
  output logic [CODE_W-1:0]      ramp_code,
  output bps_pkg::bps_state_t    channel_state
);

  localparam logic [2:0]  OC_COUNT_MAX = 3'(`BPS_OC_FAULT_COUNT);
  localparam logic [2:0]  HIC_RISES    = 3'(`BPS_HICCUP_RISES);
  localparam logic [1:0]  MID_CYC      = 2'(`BPS_PWM_MID_CYC);
  localparam int unsigned PG_W         = $clog2(PG_DELAY_CYC + 1);

  // Control pin and input-voltage flag are asynchronous to clk
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic vin_meta_reg;
  logic vin_sync_reg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      vin_meta_reg <= 1'b0;
      vin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= channel_control_pin;
      pin_sync_reg <= pin_meta_reg;
      vin_meta_reg <= vin_ok;
      vin_sync_reg <= vin_meta_reg;
    end
  end

  bps_pkg::bps_state_t state_reg;
  bps_pkg::bps_state_t state_next;
  logic [DLY_W-1:0]    dly_cnt_reg;
  logic [DLY_W-1:0]    step_cnt_reg;
  logic [CODE_W-1:0]   ramp_reg;
  logic [2:0]          oc_cnt_reg;
  logic [2:0]          rise_cnt_reg;
  logic                latch_armed_reg;
  logic                enable_req;
  logic                ramp_step;
  logic                ramp_done;
  logic                oc_trip;
  logic                oc_cycle_seen_reg;
  logic                oc_hit;
  logic                eff_latch;

  assign enable_req = vin_sync_reg                          // see [RULE3]
                    & (~use_op_cmd | op_on_cmd)
                    & (~use_control_pin | pin_sync_reg);
  assign ramp_step  = (step_cnt_reg >= soft_start_step_cyc);
  assign ramp_done  = ramp_step && (ramp_reg >= target_code);
  assign oc_trip    = (peak_current > oc_fault_limit);
  assign eff_latch  = is_slave ? master_oc_latch : oc_resp_latch;  // see [RULE18]
  // Seventh successive tripped switching cycle outside soft-start
  assign oc_hit     = (state_reg == bps_pkg::BPS_RUN || state_reg == bps_pkg::BPS_OFF_DLY)
                    && sw_cycle_start && oc_cycle_seen_reg
                    && (oc_cnt_reg == OC_COUNT_MAX - 3'h1);        // see [RULE15]

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bps_pkg::BPS_OFF: begin
        if (enable_req) begin
          state_next = bps_pkg::BPS_ON_DLY;
        end
      end
      bps_pkg::BPS_ON_DLY: begin
        if (!enable_req) begin
          state_next = bps_pkg::BPS_OFF;
        end else if (dly_cnt_reg >= turn_on_delay_cyc) begin    // see [RULE4]
          state_next = bps_pkg::BPS_SOFT;
        end
      end
      bps_pkg::BPS_SOFT: begin
        if (!enable_req) begin
          state_next = bps_pkg::BPS_OFF_DLY;
        end else if (ramp_done) begin
          state_next = bps_pkg::BPS_RUN;
        end
      end
      bps_pkg::BPS_RUN: begin
        if (oc_hit) begin
          state_next = eff_latch ? bps_pkg::BPS_LATCHED : bps_pkg::BPS_HICCUP;  // see [RULE17]
        end else if (!enable_req) begin
          state_next = bps_pkg::BPS_OFF_DLY;
        end
      end
      bps_pkg::BPS_OFF_DLY: begin
        // A new turn-on is not taken until the channel is fully off
        if (oc_hit) begin
          state_next = eff_latch ? bps_pkg::BPS_LATCHED : bps_pkg::BPS_HICCUP;
        end else if (dly_cnt_reg >= turn_off_delay_cyc) begin   // see [RULE4] see [RULE5]
          state_next = bps_pkg::BPS_OFF;
        end
      end
      bps_pkg::BPS_HICCUP: begin
        if (!enable_req) begin
          state_next = bps_pkg::BPS_OFF;
        end else if (ramp_done && rise_cnt_reg == HIC_RISES - 3'h1) begin
          state_next = bps_pkg::BPS_SOFT;                      // see [RULE17]
        end
      end
      bps_pkg::BPS_LATCHED: begin
        // Only a low-then-high toggle of the control pin frees it
        if (latch_armed_reg && pin_sync_reg) begin
          state_next = bps_pkg::BPS_OFF;
        end
      end
      default: begin
        state_next = bps_pkg::BPS_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= bps_pkg::BPS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Delay counter restarts at every state change
  always_ff @(posedge clk) begin
    if (!reset_n || state_next != state_reg) begin
      dly_cnt_reg <= '0;
    end else if (dly_cnt_reg != '1) begin
      dly_cnt_reg <= dly_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latch_armed_reg <= 1'b0;
    end else if (state_reg != bps_pkg::BPS_LATCHED) begin
      latch_armed_reg <= 1'b0;
    end else if (!pin_sync_reg) begin
      latch_armed_reg <= 1'b1;
    end
  end

  // Soft-start ramp; in hiccup it runs unseen to time seven rises
  logic ramping;
  assign ramping = (state_reg == bps_pkg::BPS_SOFT) || (state_reg == bps_pkg::BPS_HICCUP);
  always_ff @(posedge clk) begin
    if (!reset_n || !ramping || state_next != state_reg || ramp_done) begin
      step_cnt_reg <= '0;
      ramp_reg     <= '0;
    end else if (ramp_step) begin
      step_cnt_reg <= '0;
      ramp_reg     <= ramp_reg + 1'b1;
    end else begin
      step_cnt_reg <= step_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || state_reg != bps_pkg::BPS_HICCUP) begin
      rise_cnt_reg <= '0;
    end else if (ramp_done) begin
      rise_cnt_reg <= rise_cnt_reg + 3'h1;
    end
  end

  // Overcurrent: cycle limiting always, counting only after soft-start
  // A trip on the period boundary belongs to the new period, not lost
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oc_cycle_seen_reg <= 1'b0;
    end else if (sw_cycle_start) begin
      oc_cycle_seen_reg <= oc_trip;
    end else if (oc_trip) begin
      oc_cycle_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !enable_req || state_reg == bps_pkg::BPS_SOFT) begin
      oc_cnt_reg <= '0;                                       // see [RULE16] see [RULE21]
    end else if (sw_cycle_start && (state_reg == bps_pkg::BPS_RUN || state_reg == bps_pkg::BPS_OFF_DLY)) begin
      if (!oc_cycle_seen_reg || oc_hit) begin
        oc_cnt_reg <= '0;
      end else begin
        oc_cnt_reg <= oc_cnt_reg + 3'h1;                      // see [RULE15]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oc_fault <= 1'b0;
      oc_warn  <= 1'b0;
    end else begin
      if (oc_hit) begin
        oc_fault <= 1'b1;
      end else if (state_reg == bps_pkg::BPS_OFF) begin
        oc_fault <= 1'b0;
      end
      oc_warn <= (peak_current > oc_warn_limit);              // see [RULE14]
    end
  end

  // Settings
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oc_resp_latch   <= `BPS_RESP_RESET;
      cal_gain        <= `BPS_CAL_RESET_UOHM;
      cal_gain_reject <= 1'b0;
    end else begin
      if (oc_resp_wr && !is_slave) begin
        oc_resp_latch <= oc_resp_latch_data;                  // see [RULE18]
      end
      cal_gain_reject <= 1'b0;
      if (cal_gain_wr) begin
        if (cal_gain_data >= `BPS_CAL_MIN_UOHM && cal_gain_data <= `BPS_CAL_MAX_UOHM) begin
          cal_gain <= cal_gain_data;                          // see [RULE19]
        end else begin
          cal_gain_reject <= 1'b1;
        end
      end
    end
  end

  // Pre-bias: high side waits for ramp to reach feedback, then duty opens up
  logic              hs_allowed_reg;
  logic [DUTY_W-1:0] duty_lim_reg;
  logic [DUTY_W-1:0] phase_cnt_reg;
  always_ff @(posedge clk) begin
    if (!reset_n || state_reg != bps_pkg::BPS_SOFT && state_reg != bps_pkg::BPS_RUN
        && state_reg != bps_pkg::BPS_OFF_DLY) begin
      hs_allowed_reg <= 1'b0;
      duty_lim_reg   <= '0;
    end else begin
      // Ramp is idle after soft-start, so only soft-start holds the high side back
      if (state_reg != bps_pkg::BPS_SOFT || ramp_reg >= feedback_sense) begin
        hs_allowed_reg <= 1'b1;                               // see [RULE7]
      end
      if (hs_allowed_reg && sw_cycle_start && duty_lim_reg < duty_ramp_max) begin
        duty_lim_reg <= duty_lim_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || sw_cycle_start) begin
      phase_cnt_reg <= '0;
    end else if (phase_cnt_reg != '1) begin
      phase_cnt_reg <= phase_cnt_reg + 1'b1;
    end
  end

  // PWM level choice
  bps_pkg::bps_pwm_t pwm_want;
  bps_pkg::bps_pwm_t pwm_reg;
  logic              pulse_cut;
  assign pulse_cut = oc_trip || oc_cycle_seen_reg;            // see [RULE13]
  always_comb begin
    pwm_want = bps_pkg::BPS_PWM_REL;
    if (hs_allowed_reg) begin
      if (pwm_demand && !pulse_cut && phase_cnt_reg < duty_lim_reg) begin
        pwm_want = bps_pkg::BPS_PWM_HIGH;
      end else begin
        pwm_want = bps_pkg::BPS_PWM_LOW;                      // see [RULE1]
      end
    end
  end

  logic [1:0] mid_cnt_reg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwm_reg     <= bps_pkg::BPS_PWM_REL;
      mid_cnt_reg <= '0;
    end else begin
      pwm_reg <= pwm_want;
      if (pwm_want == bps_pkg::BPS_PWM_REL && pwm_reg != bps_pkg::BPS_PWM_REL) begin
        mid_cnt_reg <= MID_CYC;                               // see [RULE2]
      end else if (pwm_want != bps_pkg::BPS_PWM_REL) begin
        mid_cnt_reg <= '0;
      end else if (mid_cnt_reg != 2'h0) begin
        mid_cnt_reg <= mid_cnt_reg - 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwm_drive_hi <= 1'b0;
      pwm_oe       <= 1'b0;
      pwm_mid_en   <= 1'b0;
    end else begin
      pwm_drive_hi <= (pwm_want == bps_pkg::BPS_PWM_HIGH);    // see [RULE1]
      pwm_mid_en   <= (pwm_want == bps_pkg::BPS_PWM_REL) &&
                      ((pwm_reg != bps_pkg::BPS_PWM_REL) || (mid_cnt_reg > 2'h1));  // see [RULE2]
      pwm_oe       <= (pwm_want != bps_pkg::BPS_PWM_REL) ||
                      ((pwm_reg != bps_pkg::BPS_PWM_REL) || (mid_cnt_reg > 2'h1));
    end
  end

  // Power-good
  logic            in_window;
  logic [PG_W-1:0] pg_cnt_reg;
  assign in_window = (feedback_sense >= good_window_lower_limit)  // see [RULE12]
                  && (feedback_sense <= good_window_upper_limit);
  always_ff @(posedge clk) begin
    if (!reset_n || state_reg != bps_pkg::BPS_RUN || !in_window) begin
      pg_cnt_reg     <= '0;
      power_good_out <= 1'b0;                                 // see [RULE8] see [RULE11]
    end else if (pg_delay_disable) begin
      power_good_out <= 1'b1;                                 // see [RULE10]
    end else if (pg_cnt_reg >= PG_W'(PG_DELAY_CYC - 1)) begin
      power_good_out <= 1'b1;                                 // see [RULE9]
    end else begin
      pg_cnt_reg <= pg_cnt_reg + 1'b1;
    end
  end

  assign soft_start_active = (state_reg == bps_pkg::BPS_SOFT);
  assign ramp_code         = ramp_reg;
  assign channel_state     = state_reg;

endmodule
`default_nettype wire

// ### bench/bps_stage_model.sv
// Power stage model on the far side of the three-level pin
`timescale 1ns/100ps
`default_nettype none
module bps_stage_model #(
  parameter logic [9:0] PREBIAS = 10'h014
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       pwm_drive_hi,
  input  wire logic       pwm_oe,
  input  wire logic       pwm_mid_en,
  output logic [9:0]      feedback_sense
);
  logic hs_on;
  logic ls_on;
  // Mid level and open pin both leave the two switches off
  assign hs_on = pwm_oe && !pwm_mid_en && pwm_drive_hi;
  assign ls_on = pwm_oe && !pwm_mid_en && !pwm_drive_hi;
  // Load holds the pre-bias level, so output never sinks below it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      feedback_sense <= PREBIAS;
    end else if (hs_on && feedback_sense != 10'h3ff) begin
      feedback_sense <= feedback_sense + 10'h001;
    end else if (ls_on && feedback_sense > PREBIAS) begin
      feedback_sense <= feedback_sense - 10'h001;
    end
  end
endmodule
`default_nettype wire

// ### bench/bps_channel_props.sv
// Concurrent checks on the buck channel ports
`timescale 1ns/100ps
`default_nettype none
module bps_channel_props #(
  parameter int unsigned CODE_W       = 10,
  parameter int unsigned PG_DELAY_CYC = 20000
) (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic [CODE_W-1:0]   feedback_sense,
  input wire logic [CODE_W-1:0]   peak_current,
  input wire logic [CODE_W-1:0]   oc_fault_limit,
  input wire logic [CODE_W-1:0]   oc_warn_limit,
  input wire logic [CODE_W-1:0]   good_window_lower_limit,
  input wire logic [CODE_W-1:0]   good_window_upper_limit,
  input wire logic                pg_delay_disable,
  input wire logic                is_slave,
  input wire logic                master_oc_latch,
  input wire logic                cal_gain_wr,
  input wire logic [15:0]         cal_gain_data,
  input wire logic                pwm_drive_hi,
  input wire logic                pwm_oe,
  input wire logic                pwm_mid_en,
  input wire logic                power_good_out,
  input wire logic                oc_fault,
  input wire logic                oc_warn,
  input wire logic                oc_resp_latch,
  input wire logic [15:0]         cal_gain,
  input wire logic                cal_gain_reject,
  input wire logic                soft_start_active,
  input wire logic [CODE_W-1:0]   ramp_code,
  input wire bps_pkg::bps_state_t channel_state
);
  logic        pin_hi;
  logic        in_win;
  logic        resp_sel;
  logic        hi_seen;
  int unsigned run_cnt;
  assign pin_hi = pwm_oe && pwm_drive_hi && !pwm_mid_en;
  assign in_win = feedback_sense >= good_window_lower_limit && feedback_sense <= good_window_upper_limit;
  assign resp_sel = is_slave ? master_oc_latch : oc_resp_latch;
  always_ff @(posedge clk) begin
    if (!reset_n || channel_state != bps_pkg::BPS_RUN || !in_win) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= run_cnt + 1;
    end
  end
  // Once switching started in a ramp, feedback may pass the ramp again
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hi_seen <= 1'b0;
    end else begin
      hi_seen <= soft_start_active && (hi_seen || pin_hi);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_driven;
    pwm_oe && !pwm_mid_en;
  endsequence
  sequence s_trip;
    peak_current > oc_fault_limit;
  endsequence
  AST_MID_ONE: assert property (pwm_mid_en |-> pwm_oe ##1 !pwm_mid_en)
    else $error("mid level not a single driven cycle");
  AST_REL_VIA_MID: assert property (s_driven |=> pwm_oe)
    else $error("pin released without mid level");
  AST_PREBIAS: assert property (soft_start_active && !hi_seen && ramp_code < feedback_sense |=> !pin_hi)
    else $error("high side before ramp reached feedback");
  AST_PG_SOFT: assert property (soft_start_active |-> !power_good_out)
    else $error("power good during soft start");
  AST_PG_QUAL: assert property ($rose(power_good_out) && !$past(pg_delay_disable) |-> run_cnt >= PG_DELAY_CYC - 1)
    else $error("power good before qualification delay");
  AST_PG_WIN: assert property (!in_win |=> !power_good_out)
    else $error("power good outside window");
  AST_OC_CUT: assert property (s_trip |=> !pin_hi)
    else $error("pulse not ended on overcurrent");
  AST_OC_WARN: assert property (peak_current > oc_warn_limit |=> oc_warn)
    else $error("warning missed");
  AST_OC_SOFT: assert property (soft_start_active && !oc_fault |=> !oc_fault)
    else $error("fault raised during soft start");
  // State flips with the fault, the mid cycle follows two edges later, then the pin floats
  AST_OC_RESP: assert property ($rose(oc_fault) |-> channel_state == ($past(resp_sel) ? bps_pkg::BPS_LATCHED : bps_pkg::BPS_HICCUP) ##3 !pwm_oe)
    else $error("wrong overcurrent response");
  AST_CAL_BAD: assert property (cal_gain_wr && !(cal_gain_data inside {[16'h00f4:16'h1e43]}) |=> cal_gain_reject && $stable(cal_gain))
    else $error("out of range sense setting taken");
endmodule
bind bps_channel bps_channel_props #(.CODE_W(CODE_W), .PG_DELAY_CYC(PG_DELAY_CYC)) u_props (
  .clk, .reset_n, .feedback_sense, .peak_current, .oc_fault_limit, .oc_warn_limit, .good_window_lower_limit,
  .good_window_upper_limit, .pg_delay_disable, .is_slave, .master_oc_latch, .cal_gain_wr, .cal_gain_data,
  .pwm_drive_hi, .pwm_oe, .pwm_mid_en, .power_good_out, .oc_fault, .oc_warn, .oc_resp_latch, .cal_gain,
  .cal_gain_reject, .soft_start_active, .ramp_code, .channel_state
);
`default_nettype wire

// ### bench/tb_bps_channel.sv
// Self-checking bench for the buck channel sequencing and fault logic
`timescale 1ns/100ps
`default_nettype none
module tb_bps_channel;
  localparam int PG   = 20;
  localparam int RISE = 160;
  logic clk, reset_n, op_on_cmd, use_op_cmd, use_control_pin, channel_control_pin, vin_ok;
  logic pg_delay_disable, is_slave, master_oc_latch, oc_resp_wr, oc_resp_latch_data, cal_gain_wr;
  logic sw_cycle_start, pwm_demand, trip, pwm_drive_hi, pwm_oe, pwm_mid_en, power_good_out;
  logic oc_fault, oc_warn, oc_resp_latch, cal_gain_reject, soft_start_active;
  logic [15:0] on_d, off_d, cal_gain_data, cal_gain, prev;
  logic [9:0]  peak_current, oc_fault_limit, oc_warn_limit, lo, hi, feedback_sense, ramp_code;
  logic [15:0] cv [6];
  bps_pkg::bps_state_t channel_state;
  int num_errors = 0, cmp_count = 0, seed = 61645, ph = 0, n = 0;
  // Ramp of 80 codes at one code per two clocks
  bps_channel #(.PG_DELAY_CYC(PG)) uut (
    .clk, .reset_n, .op_on_cmd, .use_op_cmd, .use_control_pin, .channel_control_pin, .vin_ok,
    .turn_on_delay_cyc(on_d), .turn_off_delay_cyc(off_d), .soft_start_step_cyc(16'h0001),
    .target_code(10'h050), .feedback_sense, .duty_ramp_max(8'h20), .sw_cycle_start, .pwm_demand,
    .peak_current, .oc_fault_limit, .oc_warn_limit, .good_window_lower_limit(lo),
    .good_window_upper_limit(hi), .pg_delay_disable, .is_slave, .master_oc_latch, .oc_resp_wr,
    .oc_resp_latch_data, .cal_gain_wr, .cal_gain_data, .pwm_drive_hi, .pwm_oe, .pwm_mid_en,
    .power_good_out, .oc_fault, .oc_warn, .oc_resp_latch, .cal_gain, .cal_gain_reject,
    .soft_start_active, .ramp_code, .channel_state
  );
  bps_stage_model stage (.clk, .reset_n, .pwm_drive_hi, .pwm_oe, .pwm_mid_en, .feedback_sense);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic cal_ok(input logic [15:0] v);
    return v >= 16'h00f4 && v <= 16'h1e43;
  endfunction
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    chk_val(nm, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic wait_st(input bps_pkg::bps_state_t s, input int lim);
    n = 0;
    while (channel_state !== s) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        num_errors++;
        $display("CHECK FAILED state exp %s got %s", s.name(), channel_state.name());
        test_done();
      end
    end
  endtask
  task automatic wait_pg;
    n = 0;
    while (power_good_out !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (power_good_out !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED power_good exp 1 got %b", power_good_out);
      test_done();
    end
  endtask
  task automatic run_up;
    wait_st(bps_pkg::BPS_ON_DLY, 8);
    wait_st(bps_pkg::BPS_SOFT, 40);
    chk_val("on_delay", on_d + 16'h0001, 16'(n));
    wait_st(bps_pkg::BPS_RUN, 2000);
  endtask
  // Strobe drops for a full cycle so back-to-back writes stay apart
  task automatic wr_resp(input logic d);
    oc_resp_latch_data = d;
    oc_resp_wr = 1'b1;
    @(negedge clk);
    oc_resp_wr = 1'b0;
    @(negedge clk);
  endtask
  // Every switching period trips once while trip is set
  always @(negedge clk) begin
    ph <= (ph + 1) % 8;
    sw_cycle_start <= ph == 7;
    pwm_demand <= 1'($random(seed));
    peak_current <= (trip && ph == 3) ? oc_fault_limit + 10'h005 : 10'({$random(seed)} % 300);
  end
  initial begin
    {op_on_cmd, use_op_cmd, use_control_pin, channel_control_pin, vin_ok, pg_delay_disable} = '0;
    {is_slave, master_oc_latch, oc_resp_wr, oc_resp_latch_data, cal_gain_wr, trip} = '0;
    {reset_n, on_d, off_d, cal_gain_data, lo} = '0;
    hi = 10'h3ff;
    oc_fault_limit = 10'h200;
    oc_warn_limit = 10'h096;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    chk_val("cal_gain", 16'h01f4, cal_gain);
    chk_val("state", 16'(bps_pkg::BPS_OFF), 16'(channel_state));
    $display("test reset done");
    cv = '{16'h00f3, 16'h00f4, 16'h1e43, 16'h1e44, 16'(16'h00f4 + {$random(seed)} % 7504), 16'h01f4};
    foreach (cv[i]) begin
      prev = cal_gain;
      cal_gain_data = cv[i];
      cal_gain_wr = 1'b1;
      @(negedge clk);
      cal_gain_wr = 1'b0;
      chk_val("cal_gain", cal_ok(cv[i]) ? cv[i] : prev, cal_gain);
      chk_bit("cal_reject", !cal_ok(cv[i]), cal_gain_reject);
      @(negedge clk);
    end
    $display("test sense setting done");
    // One controller; a stacked pair would share both delays
    on_d = 16'(1 + {$random(seed)} % 15);
    off_d = 16'(1 + {$random(seed)} % 15);
    vin_ok = 1'b1;
    run_up();
    wait_pg();
    chk_bit("pg_delay", 1'b1, n >= PG - 1 && n <= PG + 1);
    hi = 10'h000;
    @(negedge clk);
    chk_bit("pg_window", 1'b0, power_good_out);
    hi = 10'h3ff;
    repeat (PG / 2) @(negedge clk);
    chk_bit("pg_requal", 1'b0, power_good_out);
    wait_pg();
    pg_delay_disable = 1'b1;
    hi = 10'h000;
    @(negedge clk);
    hi = 10'h3ff;
    repeat (3) @(negedge clk);
    chk_bit("pg_nodelay", 1'b1, power_good_out);
    pg_delay_disable = 1'b0;
    $display("test power good done");
    trip = 1'b1;
    wait_st(bps_pkg::BPS_HICCUP, 80);
    chk_bit("oc_count", 1'b1, n >= 48 && n <= 64);
    chk_bit("oc_fault", 1'b1, oc_fault);
    wait_st(bps_pkg::BPS_SOFT, 2000);
    chk_bit("hiccup_wait", 1'b1, n >= 6 * RISE && n <= 8 * RISE);
    wait_st(bps_pkg::BPS_RUN, 400);
    trip = 1'b0;
    $display("test hiccup done");
    op_on_cmd = 1'b1;
    use_op_cmd = 1'b1;
    @(negedge clk);
    op_on_cmd = 1'b0;
    wait_st(bps_pkg::BPS_OFF_DLY, 8);
    wait_st(bps_pkg::BPS_OFF, 40);
    chk_val("off_delay", off_d + 16'h0001, 16'(n));
    // Fault clears on the first edge spent in the off state
    @(negedge clk);
    chk_bit("oc_fault", 1'b0, oc_fault);
    $display("test shutdown done");
    wr_resp(1'b1);
    chk_bit("resp_own", 1'b1, oc_resp_latch);
    is_slave = 1'b1;
    wr_resp(1'b0);
    chk_bit("resp_slave", 1'b1, oc_resp_latch);
    op_on_cmd = 1'b1;
    run_up();
    trip = 1'b1;
    wait_st(bps_pkg::BPS_HICCUP, 80);
    trip = 1'b0;
    op_on_cmd = 1'b0;
    wait_st(bps_pkg::BPS_OFF, 2000);
    is_slave = 1'b0;
    use_control_pin = 1'b1;
    channel_control_pin = 1'b1;
    op_on_cmd = 1'b1;
    run_up();
    trip = 1'b1;
    wait_st(bps_pkg::BPS_LATCHED, 80);
    trip = 1'b0;
    channel_control_pin = 1'b0;
    repeat (5) @(negedge clk);
    channel_control_pin = 1'b1;
    wait_st(bps_pkg::BPS_ON_DLY, 20);
    chk_bit("oc_fault", 1'b0, oc_fault);
    $display("test latch done");
    test_done();
  end
endmodule
`default_nettype wire
